/* File: core/priority_interrupt_controller.sv */
// Two-level vectored priority interrupt controller with APB registers
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
module priority_interrupt_controller
	import pic_pkg::*;
(
	// Clock and reset
	input  wire logic               CLOCK,
	input  wire logic               RST_N,
	// APB slave
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [7:0]         PADDR,
	input  wire logic [31:0]        PWDATA,
	output logic      [31:0]        PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR,
	// Request sources
	input  wire logic               EXT_REQ_LINE_A_N,
	input  wire logic               EXT_REQ_LINE_B_N,
	input  wire logic               TIMER_A_OVERFLOW,
	input  wire logic               TIMER_B_OVERFLOW,
	input  wire logic               SERIAL_RX_DONE,
	input  wire logic               SERIAL_TX_DONE,
	input  wire logic [XSRC_HI:XSRC_LO] EXT_REQUEST_BUS,
	output logic      [XSRC_HI:XSRC_LO] EXT_ACKNOWLEDGE_BUS,
	// Instruction sequencer
	input  wire logic               INSTR_LAST,
	input  wire logic               VECTOR_TAKEN,
	input  wire logic               RETI_EXEC,
	output logic                    VECTOR_REQ,
	output logic      [15:0]        VECTOR_ADDR
);
	// ----------------------------------------------------------------
	// Machine cycle divider and pin sampling
	// ----------------------------------------------------------------
	logic        mc_phase, next_mc_phase;
	logic [1:0]  sync1, sync2, samp;
	logic [1:0]  next_sync1, next_sync2, next_samp;
	logic        mc_en;
	logic [1:0]  fall;

	always_comb begin
		next_mc_phase = ~mc_phase;
		mc_en         = mc_phase;
		next_sync1    = {EXT_REQ_LINE_B_N, EXT_REQ_LINE_A_N};
		next_sync2    = sync1;
		next_samp     = mc_en ? sync2 : samp;
		// Edge seen only between two machine-cycle samples, hence the hold times
		fall          = {2{mc_en}} & samp & ~sync2;
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			mc_phase <= 1'b0;
			sync1    <= 2'b11;
			sync2    <= 2'b11;
			samp     <= 2'b11;
		end else begin
			mc_phase <= next_mc_phase;
			sync1    <= next_sync1;
			sync2    <= next_sync2;
			samp     <= next_samp;
		end
	end

	// ----------------------------------------------------------------
	// Registers and flags
	// ----------------------------------------------------------------
	logic [7:0]  enable_lo_reg, priority_lo_reg, enable_hi_reg, priority_hi_reg;
	logic [7:0]  timer_control_reg, serial_control_reg;
	logic [7:0]  next_enable_lo, next_priority_lo, next_enable_hi, next_priority_hi;
	logic [7:0]  next_timer_control, next_serial_control;
	logic [31:0] next_prdata;
	logic        wr_en, rd_en, mapped;
	src_vec_type clr_vec, pend, en_vec, pr_vec;
	logic        ext_a_pending_flag, ext_b_pending_flag;
	vec_state_type state, next_state;
	pick_type    sel, next_sel;
	logic        act_hi, act_lo, next_act_hi, next_act_lo;
	logic [15:0] next_vector_addr;

	assign wr_en   = PSEL & PENABLE & PWRITE;
	assign rd_en   = PSEL & ~PENABLE & ~PWRITE;
	assign mapped  = (PADDR[7:5] == 3'h0) & (PADDR[1:0] == 2'h0);
	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;

	// Level mode shows the inverted machine-cycle pin sample; edge mode shows the stored flag
	assign ext_a_pending_flag = timer_control_reg[TC_EXT_A_EDGE] ?
		timer_control_reg[TC_EXT_A_FLAG] : ~samp[0];
	assign ext_b_pending_flag = timer_control_reg[TC_EXT_B_EDGE] ?
		timer_control_reg[TC_EXT_B_FLAG] : ~samp[1];

	always_comb begin
		next_enable_lo      = enable_lo_reg;
		next_enable_hi      = enable_hi_reg;
		next_priority_lo    = priority_lo_reg;
		next_priority_hi    = priority_hi_reg;
		next_timer_control  = timer_control_reg;
		next_serial_control = serial_control_reg;
		if (wr_en) begin
			unique case (PADDR)
				ADDR_ENABLE_LO:   next_enable_lo      = PWDATA[7:0];
				ADDR_ENABLE_HI:   next_enable_hi      = PWDATA[7:0];
				ADDR_PRIORITY_LO: next_priority_lo    = PWDATA[7:0];
				ADDR_PRIORITY_HI: next_priority_hi    = PWDATA[7:0];
				ADDR_TIMER_CTRL:  next_timer_control  = PWDATA[7:0];
				ADDR_SERIAL_CTRL: next_serial_control = PWDATA[7:0];
				default:          next_enable_lo      = enable_lo_reg;
			endcase
		end
		// Hardware clears only on vectoring; the serial flags are left alone
		if (!(wr_en && (PADDR == ADDR_TIMER_CTRL))) begin
			next_timer_control[TC_EXT_A_FLAG]   = timer_control_reg[TC_EXT_A_FLAG] &
				~clr_vec[SRC_EXT_A];
			next_timer_control[TC_EXT_B_FLAG]   = timer_control_reg[TC_EXT_B_FLAG] &
				~clr_vec[SRC_EXT_B];
			next_timer_control[TC_TIMER_A_FLAG] = timer_control_reg[TC_TIMER_A_FLAG] &
				~clr_vec[SRC_TIMER_A];
			next_timer_control[TC_TIMER_B_FLAG] = timer_control_reg[TC_TIMER_B_FLAG] &
				~clr_vec[SRC_TIMER_B];
		end
		// Set beats any clear in the same cycle
		next_timer_control[TC_EXT_A_FLAG] = timer_control_reg[TC_EXT_A_EDGE] &
			(fall[0] | next_timer_control[TC_EXT_A_FLAG]);
		next_timer_control[TC_EXT_B_FLAG] = timer_control_reg[TC_EXT_B_EDGE] &
			(fall[1] | next_timer_control[TC_EXT_B_FLAG]);
		next_timer_control[TC_TIMER_A_FLAG] = next_timer_control[TC_TIMER_A_FLAG] |
			TIMER_A_OVERFLOW;
		next_timer_control[TC_TIMER_B_FLAG] = next_timer_control[TC_TIMER_B_FLAG] |
			TIMER_B_OVERFLOW;
		next_serial_control[SC_RX_FLAG] = next_serial_control[SC_RX_FLAG] |
			SERIAL_RX_DONE;
		next_serial_control[SC_TX_FLAG] = next_serial_control[SC_TX_FLAG] |
			SERIAL_TX_DONE;
		next_prdata = 32'h0000_0000;
		if (rd_en) begin
			unique case (PADDR)
				ADDR_ENABLE_LO:   next_prdata[7:0]   = enable_lo_reg;
				ADDR_ENABLE_HI:   next_prdata[7:0]   = enable_hi_reg;
				ADDR_PRIORITY_LO: next_prdata[7:0]   = priority_lo_reg;
				ADDR_PRIORITY_HI: next_prdata[7:0]   = priority_hi_reg;
				ADDR_TIMER_CTRL:  next_prdata[7:0]   = timer_control_reg;
				ADDR_SERIAL_CTRL: next_prdata[7:0]   = serial_control_reg;
				ADDR_STATUS:      next_prdata[11:0]  = {sel.idx, 5'h00, VECTOR_REQ, act_hi, act_lo};
				ADDR_PENDING:     next_prdata[13:0]  = pend;
				default:          next_prdata        = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			enable_lo_reg      <= REG_RESET;
			enable_hi_reg      <= REG_RESET;
			priority_lo_reg    <= REG_RESET;
			priority_hi_reg    <= REG_RESET;
			timer_control_reg  <= REG_RESET;
			serial_control_reg <= REG_RESET;
			PRDATA             <= 32'h0000_0000;
		end else begin
			enable_lo_reg      <= next_enable_lo;
			enable_hi_reg      <= next_enable_hi;
			priority_lo_reg    <= next_priority_lo;
			priority_hi_reg    <= next_priority_hi;
			timer_control_reg  <= next_timer_control;
			serial_control_reg <= next_serial_control;
			PRDATA             <= next_prdata;
		end
	end

	// ----------------------------------------------------------------
	// Arbitration and vectoring
	// ----------------------------------------------------------------
	pick_type    pick_h, pick_l, choice;
	src_vec_type elig_hi, elig_lo;

	always_comb begin
		// Extended lines are plain levels from same-clock logic
		pend = {EXT_REQUEST_BUS, serial_control_reg[SC_RX_FLAG] | serial_control_reg[SC_TX_FLAG],
			timer_control_reg[TC_TIMER_B_FLAG], ext_b_pending_flag,
			timer_control_reg[TC_TIMER_A_FLAG], ext_a_pending_flag};
		en_vec  = {enable_hi_reg, enable_lo_reg[5:0]};
		pr_vec  = {priority_hi_reg, priority_lo_reg[5:0]};
		elig_hi = pend & en_vec & pr_vec & {NUM_SRC{~act_hi}};
		elig_lo = pend & en_vec & ~pr_vec & {NUM_SRC{~act_hi & ~act_lo}};
		pick_h  = first_pending(elig_hi, 1'b1);
		pick_l  = first_pending(elig_lo, 1'b0);
		choice  = pick_h.valid ? pick_h : pick_l;
		next_state       = state;
		next_sel         = sel;
		next_act_hi      = act_hi;
		next_act_lo      = act_lo;
		next_vector_addr = VECTOR_ADDR;
		clr_vec          = '0;
		unique case (state)
			ST_IDLE: begin
				// Deciding only at instruction ends bounds the latency
				if (INSTR_LAST && choice.valid) begin
					next_state       = ST_CALL;
					next_sel         = choice;
					next_vector_addr = vector_of(choice.idx);
				end
			end
			ST_CALL: begin
				// Choice frozen until the call is taken; others wait
				if (VECTOR_TAKEN) begin
					next_state = ST_IDLE;
					clr_vec    = src_vec_type'(1) << sel.idx;
					if (sel.high) begin
						next_act_hi = 1'b1;
					end else begin
						next_act_lo = 1'b1;
					end
				end
			end
		endcase
		if (RETI_EXEC && state == ST_IDLE) begin
			if (act_hi) begin
				next_act_hi = 1'b0;
			end else begin
				next_act_lo = 1'b0;
			end
		end
	end

	assign VECTOR_REQ          = (state == ST_CALL);
	assign EXT_ACKNOWLEDGE_BUS = clr_vec[XSRC_HI:XSRC_LO];

	always_ff @(posedge CLOCK or negedge RST_N) begin
		if (!RST_N) begin
			state       <= ST_IDLE;
			sel         <= '0;
			act_hi      <= 1'b0;
			act_lo      <= 1'b0;
			VECTOR_ADDR <= 16'h0000;
		end else begin
			state       <= next_state;
			sel         <= next_sel;
			act_hi      <= next_act_hi;
			act_lo      <= next_act_lo;
			VECTOR_ADDR <= next_vector_addr;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	property p_edge_clear;
		@(posedge CLOCK) disable iff (!RST_N)
		(VECTOR_TAKEN && VECTOR_REQ && sel.idx == SRC_EXT_A && !wr_en && !fall[0])
		|=> !timer_control_reg[TC_EXT_A_FLAG];
	endproperty
	a_edge_clear: assert property (p_edge_clear) else $error("edge flag kept");
	property p_level_follow;
		@(posedge CLOCK) disable iff (!RST_N)
		!timer_control_reg[TC_EXT_B_EDGE] |-> (ext_b_pending_flag == ~samp[1])
		##1 !timer_control_reg[TC_EXT_B_FLAG];
	endproperty
	a_level_follow: assert property (p_level_follow) else $error("level flag wrong");
	property p_timer_clear;
		@(posedge CLOCK) disable iff (!RST_N)
		(VECTOR_TAKEN && VECTOR_REQ && sel.idx == SRC_TIMER_B && !wr_en && !TIMER_B_OVERFLOW)
		|=> !timer_control_reg[TC_TIMER_B_FLAG];
	endproperty
	a_timer_clear: assert property (p_timer_clear) else $error("timer flag kept");
	property p_ack_pulse;
		@(posedge CLOCK) disable iff (!RST_N)
		(EXT_ACKNOWLEDGE_BUS != '0) |-> (VECTOR_TAKEN && VECTOR_REQ && sel.idx >= 4'h5)
		##1 (EXT_ACKNOWLEDGE_BUS == '0);
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("bad acknowledge");
	property p_vector_addr;
		@(posedge CLOCK) disable iff (!RST_N)
		VECTOR_REQ |-> (VECTOR_ADDR == 16'h0003 + 16'h0008 * {12'h000, sel.idx});
	endproperty
	a_vector_addr: assert property (p_vector_addr) else $error("wrong vector");
	property p_enabled_only;
		@(posedge CLOCK) disable iff (!RST_N)
		$rose(VECTOR_REQ) |-> $past(INSTR_LAST) &&
		((($past(en_vec) >> sel.idx) & 14'h0001) != 14'h0000);
	endproperty
	a_enabled_only: assert property (p_enabled_only) else $error("disabled vectored");
	property p_same_level;
		@(posedge CLOCK) disable iff (!RST_N)
		$rose(VECTOR_REQ) |-> !$past(act_hi) && (sel.high || !$past(act_lo));
	endproperty
	a_same_level: assert property (p_same_level) else $error("same level nested");
	property p_high_first;
		@(posedge CLOCK) disable iff (!RST_N)
		(state == ST_IDLE && INSTR_LAST && pick_h.valid) |=> VECTOR_REQ && sel.high;
	endproperty
	a_high_first: assert property (p_high_first) else $error("high not first");
	property p_frozen;
		@(posedge CLOCK) disable iff (!RST_N)
		(VECTOR_REQ && !VECTOR_TAKEN) |=> VECTOR_REQ && $stable(sel) && $stable(VECTOR_ADDR);
	endproperty
	a_frozen: assert property (p_frozen) else $error("choice changed");
	property p_reti;
		@(posedge CLOCK) disable iff (!RST_N)
		(RETI_EXEC && !VECTOR_REQ && act_hi) |=> !act_hi && ($past(act_lo) == act_lo);
	endproperty
	a_reti: assert property (p_reti) else $error("level not released");
	c_nest: cover property (@(posedge CLOCK) disable iff (!RST_N) act_lo && act_hi);
	c_ack: cover property (@(posedge CLOCK) disable iff (!RST_N) EXT_ACKNOWLEDGE_BUS[13]);
	c_edge: cover property (@(posedge CLOCK) disable iff (!RST_N) fall[0] ##[1:40] VECTOR_REQ);
endmodule : priority_interrupt_controller

/* File: core/pic_pkg.sv */
// Shared constants, types and helpers of the priority interrupt controller
package pic_pkg;
	// ----------------------------------------------------------------
	// Sources and vectors
	// ----------------------------------------------------------------
	localparam int              NUM_SRC     = 14;
	localparam int              XSRC_LO     = 5;
	localparam int              XSRC_HI     = 13;
	typedef logic [NUM_SRC-1:0] src_vec_type;
	typedef logic [3:0]         src_idx_type;
	localparam src_idx_type     SRC_EXT_A   = 4'h0;
	localparam src_idx_type     SRC_TIMER_A = 4'h1;
	localparam src_idx_type     SRC_EXT_B   = 4'h2;
	localparam src_idx_type     SRC_TIMER_B = 4'h3;
	localparam src_idx_type     SRC_SERIAL  = 4'h4;
	localparam logic [15:0]     VECTOR_BASE = 16'h0003;
	localparam logic [15:0]     VECTOR_STEP = 16'h0008;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int              MC_CLOCKS      = 2;
	localparam int              LATENCY_MIN_MC = 3;
	localparam int              LATENCY_MAX_MC = 9;
	// ----------------------------------------------------------------
	// Register map and fields
	// ----------------------------------------------------------------
	localparam logic [7:0]      ADDR_ENABLE_LO   = 8'h00;
	localparam logic [7:0]      ADDR_ENABLE_HI   = 8'h04;
	localparam logic [7:0]      ADDR_PRIORITY_LO = 8'h08;
	localparam logic [7:0]      ADDR_PRIORITY_HI = 8'h0c;
	localparam logic [7:0]      ADDR_TIMER_CTRL  = 8'h10;
	localparam logic [7:0]      ADDR_SERIAL_CTRL = 8'h14;
	localparam logic [7:0]      ADDR_STATUS      = 8'h18;
	localparam logic [7:0]      ADDR_PENDING     = 8'h1c;
	localparam logic [7:0]      REG_RESET        = 8'h00;
	localparam int              TC_EXT_A_EDGE    = 0;
	localparam int              TC_EXT_A_FLAG    = 1;
	localparam int              TC_EXT_B_EDGE    = 2;
	localparam int              TC_EXT_B_FLAG    = 3;
	localparam int              TC_TIMER_A_FLAG  = 5;
	localparam int              TC_TIMER_B_FLAG  = 7;
	localparam int              SC_RX_FLAG       = 0;
	localparam int              SC_TX_FLAG       = 1;
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_CALL = 2'b10} vec_state_type;
	typedef struct packed {
		logic        valid;
		logic        high;
		src_idx_type idx;
	} pick_type;
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic pick_type first_pending(input src_vec_type m, input logic high);
		pick_type p;
		p = '{valid: 1'b0, high: high, idx: 4'h0};
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (m[i]) begin
				p.valid = 1'b1;
				p.idx   = 4'(i);
			end
		end
		return p;
	endfunction : first_pending
	function automatic logic [15:0] vector_of(input src_idx_type idx);
		return 16'(VECTOR_BASE + VECTOR_STEP * {12'h000, idx});
	endfunction : vector_of
endpackage : pic_pkg

/* File: testbench/pic_sequencer_model.sv */
// Sequencer and extended-request peripheral model facing the interrupt controller
`timescale 1ns/1ns
module pic_sequencer_model (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Bench controls
	input  wire logic        hold,
	input  wire logic [3:0]  take_delay,
	input  wire logic [13:5] xsrc_set,
	// Controller side
	input  wire logic        vector_req,
	input  wire logic [15:0] vector_addr,
	input  wire logic [13:5] ack_bus,
	output logic             instr_last,
	output logic             vector_taken,
	output logic [13:5]      req_bus,
	output logic [15:0]      last_addr,
	output int               taken_count
);
	logic [3:0] wait_cnt;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			instr_last   <= 1'b0;
			vector_taken <= 1'b0;
			req_bus      <= 9'h000;
			last_addr    <= 16'h0000;
			taken_count  <= 0;
			wait_cnt     <= 4'h0;
		end else begin
			// Instruction ends once per machine cycle; hold lets requests pile up
			instr_last   <= !hold && !instr_last;
			wait_cnt     <= (vector_req && !vector_taken) ? wait_cnt + 4'h1 : 4'h0;
			vector_taken <= vector_req && !vector_taken && wait_cnt >= take_delay;
			if (vector_taken) begin
				last_addr   <= vector_addr;
				taken_count <= taken_count + 1;
			end
			// Levels held until acknowledged, since the controller does not edge-detect the extended lines
			req_bus <= (req_bus & ~ack_bus) | xsrc_set;
		end
	end
endmodule : pic_sequencer_model

/* File: testbench/tb_top.sv */
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ns
module tb_top
	import pic_pkg::*;
;
	logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        line_a_n, line_b_n, tmr_a, tmr_b, rx_done, tx_done;
	logic        instr_last, vector_taken, reti, vector_req, hold;
	logic [13:5] xsrc_set, req_bus, ack_bus, ack_log;
	logic [15:0] vector_addr, last_addr;
	int          taken_count, lat;
	int          fail_count = 0;
	int          compares = 0;
	int          ack_n = 0;
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	priority_interrupt_controller u_priority_interrupt_controller (
		.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.EXT_REQ_LINE_A_N(line_a_n), .EXT_REQ_LINE_B_N(line_b_n), .TIMER_A_OVERFLOW(tmr_a),
		.TIMER_B_OVERFLOW(tmr_b), .SERIAL_RX_DONE(rx_done), .SERIAL_TX_DONE(tx_done),
		.EXT_REQUEST_BUS(req_bus), .EXT_ACKNOWLEDGE_BUS(ack_bus), .INSTR_LAST(instr_last),
		.VECTOR_TAKEN(vector_taken), .RETI_EXEC(reti), .VECTOR_REQ(vector_req),
		.VECTOR_ADDR(vector_addr));
	pic_sequencer_model u_pic_sequencer_model (
		.clock(clock), .rst_n(rst_n), .hold(hold), .take_delay(4'h1), .xsrc_set(xsrc_set),
		.vector_req(vector_req), .vector_addr(vector_addr), .ack_bus(ack_bus),
		.instr_last(instr_last), .vector_taken(vector_taken), .req_bus(req_bus),
		.last_addr(last_addr), .taken_count(taken_count));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check
	task automatic close_out();
		$display("compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out
	// Entered just after a rising edge; one idle cycle after each transfer
	task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= data;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// Sampled before this edge's updates land, so the access-phase value is seen
		while (pready !== 1'b1) begin
			@(posedge clock);
		end
		rd      = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask : apb
	task automatic expect_vector(input int idx);
		int n, c0, a0;
		n  = 0;
		c0 = taken_count;
		a0 = ack_n;
		while (taken_count == c0 && n < 100) begin
			@(posedge clock);
			n++;
		end
		@(negedge clock);
		check("vector taken", 32'(c0 + 1), 32'(taken_count));
		check("vector address", 32'(16'h0003 + 16'h0008 * idx), 32'(last_addr));
		check("ack count", 32'(a0 + (idx >= XSRC_LO)), 32'(ack_n));
		if (idx >= XSRC_LO) begin
			check("ack bit", 32'(9'h001 << (idx - XSRC_LO)), 32'(ack_log));
		end
		@(posedge clock);
	endtask : expect_vector
	task automatic no_vector(input int cycles);
		int c0;
		c0 = taken_count;
		repeat (cycles) @(posedge clock);
		check("no vector", 32'(c0), 32'(taken_count));
	endtask : no_vector
	task automatic ret();
		reti <= 1'b1;
		@(posedge clock);
		reti <= 1'b0;
		@(posedge clock);
	endtask : ret
	// Acknowledge may only appear in the cycle the call is taken
	always @(posedge clock) begin
		if (ack_bus !== 9'h000) begin
			ack_log <= ack_bus;
			ack_n   <= ack_n + 1;
			check("ack with take", 1, 32'(vector_taken));
		end
	end
	initial begin
		#200000;
		fail_count++;
		close_out();
	end
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		{psel, penable, pwrite, tmr_a, tmr_b, rx_done, tx_done, reti, rst_n} = 9'h000;
		{line_a_n, line_b_n, hold} = 3'b111;
		paddr    = 8'h00;
		pwdata   = 32'h0;
		xsrc_set = 9'h000;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			check("reset value", 32'h0, rd);
		end
		apb(1'b0, 8'h20, 32'h0);
		check("unmapped error", 1, 32'(err));
		hold <= 1'b0;
		tmr_a <= 1'b1;
		@(posedge clock);
		tmr_a <= 1'b0;
		no_vector(20);
		apb(1'b1, ADDR_ENABLE_LO, 32'h02);
		expect_vector(1);
		apb(1'b0, ADDR_TIMER_CTRL, 32'h0);
		check("timer flag", 32'h0, rd);
		ret();
		$display("test enable done");
		hold <= 1'b1;
		apb(1'b1, ADDR_TIMER_CTRL, 32'h05);
		apb(1'b1, ADDR_ENABLE_LO, 32'h3f);
		apb(1'b1, ADDR_ENABLE_HI, 32'hff);
		{line_a_n, line_b_n, tmr_a, tmr_b, rx_done, tx_done} <= 6'b001111;
		xsrc_set <= 9'h1ff;
		@(posedge clock);
		{tmr_a, tmr_b, rx_done, tx_done} <= 4'b0000;
		xsrc_set <= 9'h000;
		repeat (8) @(posedge clock);
		{line_a_n, line_b_n} <= 2'b11;
		repeat (8) @(posedge clock);
		apb(1'b0, ADDR_PENDING, 32'h0);
		check("pending", 32'h0000_3fff, rd);
		hold <= 1'b0;
		for (int i = 0; i < NUM_SRC; i++) begin
			expect_vector(i);
			if (i == 0) no_vector(10);
			if (i == 4) begin
				apb(1'b0, ADDR_SERIAL_CTRL, 32'h0);
				check("serial flag", 32'h03, rd);
				apb(1'b1, ADDR_SERIAL_CTRL, 32'h0);
			end
			ret();
		end
		apb(1'b0, ADDR_TIMER_CTRL, 32'h0);
		check("flags cleared", 32'h05, rd);
		no_vector(20);
		$display("test polling done");
		hold <= 1'b1;
		apb(1'b1, ADDR_ENABLE_LO, 32'h20);
		apb(1'b1, ADDR_ENABLE_HI, 32'hc0);
		apb(1'b1, ADDR_PRIORITY_HI, 32'hc0);
		xsrc_set <= 9'h101;
		@(posedge clock);
		xsrc_set <= 9'h000;
		hold <= 1'b0;
		expect_vector(13);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check("status", 32'h0000_0d02, rd);
		no_vector(10);
		ret();
		expect_vector(5);
		// The second high request comes after the first is taken, so polling cannot reorder them
		xsrc_set <= 9'h100;
		@(posedge clock);
		xsrc_set <= 9'h000;
		expect_vector(13);
		xsrc_set <= 9'h080;
		@(posedge clock);
		xsrc_set <= 9'h000;
		no_vector(10);
		ret();
		expect_vector(12);
		ret();
		ret();
		no_vector(10);
		$display("test priority done");
		apb(1'b1, ADDR_TIMER_CTRL, 32'h00);
		apb(1'b1, ADDR_ENABLE_LO, 32'h04);
		line_b_n <= 1'b0;
		expect_vector(2);
		ret();
		expect_vector(2);
		line_b_n <= 1'b1;
		repeat (8) @(posedge clock);
		ret();
		no_vector(20);
		apb(1'b1, ADDR_ENABLE_LO, 32'h08);
		lat = 0;
		tmr_b <= 1'b1;
		@(posedge clock);
		tmr_b <= 1'b0;
		do begin
			@(negedge clock);
			lat++;
		end while (vector_taken !== 1'b1 && lat < 40);
		// First routine instruction runs after the two-machine-cycle long call
		lat = lat + 2 * MC_CLOCKS;
		check("latency", 1, 32'(lat >= LATENCY_MIN_MC * MC_CLOCKS
			&& lat <= LATENCY_MAX_MC * MC_CLOCKS));
		@(posedge clock);
		ret();
		$display("test level and latency done");
		close_out();
	end
endmodule : tb_top
